/* File: shared/sgw_pkg.sv */
package sgw_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses on the register port)
   // ------------------------------------------------------------
   localparam logic [7:0]  SGW_OFS_CTRL     = 8'h00; // control: start, direction, first-is-last
   localparam logic [7:0]  SGW_OFS_SEG_LO   = 8'h04; // first segment address, low word
   localparam logic [7:0]  SGW_OFS_SEG_HI   = 8'h08; // first segment address, high word
   localparam logic [7:0]  SGW_OFS_SEG_CNT  = 8'h0c; // descriptors in first segment
   localparam logic [7:0]  SGW_OFS_STATUS   = 8'h10; // busy, error code, transfers issued
   localparam logic [7:0]  SGW_OFS_IRQ_STAT = 8'h14; // sticky events, write one to clear
   localparam logic [7:0]  SGW_OFS_IRQ_MASK = 8'h18; // interrupt enables
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int          SGW_CTRL_START   = 0;     // write one to start a walk
   localparam int          SGW_CTRL_DEST    = 1;     // one: list describes a destination buffer
   localparam int          SGW_CTRL_LAST    = 2;     // one: first segment is the last one
   localparam int          SGW_IRQ_DONE     = 0;     // walk finished
   localparam int          SGW_IRQ_ERR      = 1;     // walk finished with an error
   localparam int          SGW_DESC_BYTES   = 16;    // bytes per descriptor
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] SGW_RST_WORD     = 32'h0000_0000;
   localparam logic [1:0]  SGW_RST_IRQ      = 2'h0;
   // ------------------------------------------------------------
   // descriptor type codes and error codes
   // ------------------------------------------------------------
   localparam logic [3:0]  SGW_TYPE_DATA    = 4'h0;  // data block
   localparam logic [3:0]  SGW_TYPE_DISCARD = 4'h1;  // discard (bit bucket)
   localparam logic [3:0]  SGW_TYPE_SEG     = 4'h2;  // next segment
   localparam logic [3:0]  SGW_TYPE_LASTSEG = 4'h3;  // final segment
   localparam logic [3:0]  SGW_TYPE_VENDOR  = 4'hf;  // vendor specific, unsupported here
   localparam logic [2:0]  SGW_ERR_NONE     = 3'h0;
   localparam logic [2:0]  SGW_ERR_TYPE     = 3'h1;  // reserved, unsupported or nonzero low nibble
   localparam logic [2:0]  SGW_ERR_LEN      = 3'h2;  // address plus length past the top
   localparam logic [2:0]  SGW_ERR_CHAIN    = 3'h3;  // chaining descriptor before the last slot
   localparam logic [2:0]  SGW_ERR_LASTSEG  = 3'h4;  // chaining descriptor inside the final segment
   localparam logic [2:0]  SGW_ERR_SEGLEN   = 3'h5;  // empty or ragged segment length
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [63:0] addr;                              // starting byte address
      logic [31:0] len;                               // byte count
      logic        discard;                           // one: drop these destination bytes
   } sgw_xfer_t;
   typedef struct packed {
      logic        done;                              // one-cycle completion pulse
      logic [2:0]  err;                               // failure code, none on success
   } sgw_cpl_t;
endpackage

/* File: src/sgw_walker.sv */
`timescale 1ns/1ns
// Contract
// R1: any buffer address and length accepted
// R2: software lengths cover the logical blocks
// R3: software aligns segments on eight bytes
// R4: abort on chaining before last slot
// R5: abort on chaining inside final segment
// R6: descriptor n sits at n*16 bytes
// R7: type from byte 15 upper nibble
// R8: reserved or unsupported type is an error
// R9: all-zero descriptor is a null entry
// R10: address bytes 7:0, length bytes 11:8
// R11: zero-length data block moves nothing
// R12: address plus length past top errors
// R13: nonzero low nibble is a type error; not checked on segment descriptors
// R14: discard descriptor skips source data
// R15: destination discard drops length bytes
// R16: source discard acts as zero length
// R17: ascending order, follow chains, stop after final
// R18: on failure stop and report completion status
module sgw_walker (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               srst,
   // register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   // descriptor fetch from host memory
   output logic                    mem_req_valid,
   output logic      [63:0]        mem_req_addr,
   input  wire logic               mem_req_ready,
   input  wire logic               mem_rsp_valid,
   input  wire logic [127:0]       mem_rsp_data,
   // transfer stream to the data mover
   output logic                    xfer_valid,
   output sgw_pkg::sgw_xfer_t      xfer,
   input  wire logic               xfer_ready,
   // command completion and interrupt
   output sgw_pkg::sgw_cpl_t       cpl,
   output logic                    irq
);
   import sgw_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // descriptor type lives in the upper nibble of byte 15
   function automatic logic [3:0] desc_type(input logic [127:0] d);
      desc_type = d[127:124];
   endfunction

   // true when address plus length runs beyond the 64-bit space
   function automatic logic past_top(input logic [63:0] a, input logic [31:0] l);
      logic [64:0] sum;
      sum = {1'b0, a} + {33'h0, l};
      past_top = sum[64] && (sum[63:0] != 64'h0);
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_DECODE, ST_ISSUE, ST_DONE} sgw_state_t;

   sgw_state_t  state_reg;                  // walker state
   logic [63:0] seg_base_reg;               // base of the segment being walked
   logic [15:0] seg_cnt_reg;                // descriptors in that segment
   logic [15:0] idx_reg;                    // current descriptor slot
   logic        in_last_reg;                // walking the segment announced as final
   logic [127:0] desc_reg;                  // descriptor under decode
   logic [2:0]  err_reg;                    // failure code of the walk
   logic [15:0] issued_reg;                 // transfers handed to the data mover
   logic        xfer_valid_reg;             // transfer on offer
   sgw_xfer_t   xfer_reg;                   // transfer contents
   sgw_cpl_t    cpl_reg;                    // completion pulse and code
   logic [2:0]  ctrl_reg;                   // direction and first-is-last, bit 0 unused
   logic [31:0] seg_lo_reg;                 // programmed first segment address, low
   logic [31:0] seg_hi_reg;                 // programmed first segment address, high
   logic [15:0] seg_cnt_cfg_reg;            // programmed first segment count
   logic [1:0]  irq_stat_reg;               // sticky events
   logic [1:0]  irq_mask_reg;               // event enables
   logic [31:0] rdata_reg;                  // read data, one cycle after the strobe

   // ------------------------------------------------------------
   // decode of the held descriptor
   // ------------------------------------------------------------
   logic [3:0]  d_type;                     // descriptor type code
   logic [3:0]  d_nib;                      // low nibble of byte 15
   logic [63:0] d_addr;                     // bytes 7:0
   logic [31:0] d_len;                      // bytes 11:8, bytes 14:12 never read
   logic        d_chain;                    // next or final segment descriptor
   logic        d_lastslot;                 // held descriptor is the segment's final slot
   logic        start;                      // software start request

   assign d_type     = desc_type(desc_reg);                               // R7
   assign d_nib      = desc_reg[123:120];
   assign d_addr     = desc_reg[63:0];                                    // R10
   assign d_len      = desc_reg[95:64];                                   // R10
   assign d_chain    = (d_type == SGW_TYPE_SEG) || (d_type == SGW_TYPE_LASTSEG);
   assign d_lastslot = (idx_reg == seg_cnt_reg - 16'h1);
   assign start      = reg_wr && (reg_addr == SGW_OFS_CTRL) && reg_wdata[SGW_CTRL_START];

   // ------------------------------------------------------------
   // walker sequence
   // ------------------------------------------------------------
   // fetches one descriptor at a time, checks it, hands it on
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg      <= ST_IDLE;
         seg_base_reg   <= 64'h0;
         seg_cnt_reg    <= 16'h0;
         idx_reg        <= 16'h0;
         in_last_reg    <= 1'b0;
         desc_reg       <= 128'h0;
         err_reg        <= SGW_ERR_NONE;
         issued_reg     <= 16'h0;
         xfer_valid_reg <= 1'b0;
         xfer_reg       <= '0;
         cpl_reg        <= '0;
      end else begin
         cpl_reg.done <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // load the first segment as programmed
               if (start) begin
                  seg_base_reg <= {seg_hi_reg, seg_lo_reg};
                  seg_cnt_reg  <= seg_cnt_cfg_reg;
                  // the start write carries the first-is-last bit; ctrl_reg is not updated yet
                  in_last_reg  <= reg_wdata[SGW_CTRL_LAST];
                  idx_reg      <= 16'h0;
                  issued_reg   <= 16'h0;
                  err_reg      <= SGW_ERR_NONE;
                  if (seg_cnt_cfg_reg == 16'h0) begin
                     err_reg   <= SGW_ERR_SEGLEN;
                     state_reg <= ST_DONE;
                  end else begin
                     state_reg <= ST_FETCH;
                  end
               end
            end
            ST_FETCH: begin
               // request offered combinationally; wait for acceptance
               if (mem_req_ready) begin
                  state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (mem_rsp_valid) begin
                  desc_reg  <= mem_rsp_data;
                  state_reg <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               if (d_chain && !d_lastslot) begin
                  err_reg   <= SGW_ERR_CHAIN;                             // R4
                  state_reg <= ST_DONE;
               end else if (d_chain && in_last_reg) begin
                  err_reg   <= SGW_ERR_LASTSEG;                           // R5
                  state_reg <= ST_DONE;
               end else if (d_chain) begin
                  // follow the chain; segment length must be whole descriptors
                  if ((d_len == 32'h0) || (d_len[3:0] != 4'h0) || (d_len[31:20] != 12'h0)) begin
                     err_reg   <= SGW_ERR_SEGLEN;
                     state_reg <= ST_DONE;
                  end else begin
                     seg_base_reg <= d_addr;                              // R17
                     seg_cnt_reg  <= d_len[19:4];
                     in_last_reg  <= (d_type == SGW_TYPE_LASTSEG);
                     idx_reg      <= 16'h0;
                     state_reg    <= ST_FETCH;
                  end
               end else if (d_type > SGW_TYPE_LASTSEG) begin
                  // reserved codes and vendor codes are both refused
                  err_reg   <= SGW_ERR_TYPE;                              // R8
                  state_reg <= ST_DONE;
               end else if (d_nib != 4'h0) begin
                  err_reg   <= SGW_ERR_TYPE;                              // R13
                  state_reg <= ST_DONE;
               end else if ((d_type == SGW_TYPE_DATA) && past_top(d_addr, d_len)) begin
                  err_reg   <= SGW_ERR_LEN;                               // R12
                  state_reg <= ST_DONE;
               end else if ((d_len == 32'h0) ||
                            ((d_type == SGW_TYPE_DISCARD) && !ctrl_reg[SGW_CTRL_DEST])) begin
                  // null entries and source-side discards move nothing
                  if (d_lastslot) begin                                   // R9 R11 R16
                     state_reg <= ST_DONE;
                  end else begin
                     idx_reg   <= idx_reg + 16'h1;
                     state_reg <= ST_FETCH;
                  end
               end else begin
                  // no alignment is imposed on the buffer
                  xfer_reg.addr    <= d_addr;                             // R1
                  xfer_reg.len     <= d_len;
                  xfer_reg.discard <= (d_type == SGW_TYPE_DISCARD);       // R14 R15
                  xfer_valid_reg   <= 1'b1;
                  state_reg        <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               // hold the transfer until the data mover takes it
               if (xfer_ready) begin
                  xfer_valid_reg <= 1'b0;
                  issued_reg     <= issued_reg + 16'h1;
                  if (d_lastslot) begin                                   // R17
                     state_reg <= ST_DONE;
                  end else begin
                     idx_reg   <= idx_reg + 16'h1;
                     state_reg <= ST_FETCH;
                  end
               end
            end
            ST_DONE: begin
               // report once and go idle; nothing more is issued
               cpl_reg.done <= 1'b1;                                      // R18
               cpl_reg.err  <= err_reg;
               state_reg    <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // descriptor n of the segment is read at base plus n*16
   assign mem_req_valid = (state_reg == ST_FETCH);
   assign mem_req_addr  = seg_base_reg + {44'h0, idx_reg, 4'h0};          // R6
   assign xfer_valid    = xfer_valid_reg;
   assign xfer          = xfer_reg;
   assign cpl           = cpl_reg;

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // configuration words
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ctrl_reg        <= 3'h0;
         seg_lo_reg      <= SGW_RST_WORD;
         seg_hi_reg      <= SGW_RST_WORD;
         seg_cnt_cfg_reg <= 16'h0;
         irq_mask_reg    <= SGW_RST_IRQ;
      end else if (reg_wr) begin
         if (reg_addr == SGW_OFS_CTRL) begin
            ctrl_reg <= {reg_wdata[SGW_CTRL_LAST], reg_wdata[SGW_CTRL_DEST], 1'b0};
         end else if (reg_addr == SGW_OFS_SEG_LO) begin
            seg_lo_reg <= reg_wdata;
         end else if (reg_addr == SGW_OFS_SEG_HI) begin
            seg_hi_reg <= reg_wdata;
         end else if (reg_addr == SGW_OFS_SEG_CNT) begin
            seg_cnt_cfg_reg <= reg_wdata[15:0];
         end else if (reg_addr == SGW_OFS_IRQ_MASK) begin
            irq_mask_reg <= reg_wdata[1:0];
         end
      end
   end

   // sticky events; a new event beats a clear in the same cycle
   logic [1:0]  irq_clr;                    // write-one-to-clear request
   logic [1:0]  irq_set;                    // completion events of this cycle, error above done
   assign irq_clr = (reg_wr && (reg_addr == SGW_OFS_IRQ_STAT)) ? reg_wdata[1:0] : 2'h0;
   assign irq_set = {cpl_reg.done && (cpl_reg.err != SGW_ERR_NONE), cpl_reg.done};
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_stat_reg <= SGW_RST_IRQ;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------
   // data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rdata_reg <= SGW_RST_WORD;
      end else if (!reg_rd) begin
         rdata_reg <= SGW_RST_WORD;
      end else if (reg_addr == SGW_OFS_CTRL) begin
         rdata_reg <= {29'h0, ctrl_reg};
      end else if (reg_addr == SGW_OFS_SEG_LO) begin
         rdata_reg <= seg_lo_reg;
      end else if (reg_addr == SGW_OFS_SEG_HI) begin
         rdata_reg <= seg_hi_reg;
      end else if (reg_addr == SGW_OFS_SEG_CNT) begin
         rdata_reg <= {16'h0, seg_cnt_cfg_reg};
      end else if (reg_addr == SGW_OFS_STATUS) begin
         rdata_reg <= {issued_reg, 9'h0, err_reg, 3'h0, (state_reg != ST_IDLE)};
      end else if (reg_addr == SGW_OFS_IRQ_STAT) begin
         rdata_reg <= {30'h0, irq_stat_reg};
      end else if (reg_addr == SGW_OFS_IRQ_MASK) begin
         rdata_reg <= {30'h0, irq_mask_reg};
      end else begin
         rdata_reg <= SGW_RST_WORD;
      end
   end

   assign reg_rdata = rdata_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_CHAIN_SLOT: assert property (@(posedge clk_sys) disable iff (srst) // R4
      (state_reg == ST_DECODE) && d_chain && !d_lastslot |=> (err_reg == SGW_ERR_CHAIN) ##1 cpl.done)
      else $error("misplaced chaining descriptor not aborted");
   AST_LAST_SEG: assert property (@(posedge clk_sys) disable iff (srst) // R5
      (state_reg == ST_DECODE) && d_chain && d_lastslot && in_last_reg |=> ##1 (cpl.err == SGW_ERR_LASTSEG))
      else $error("chaining inside final segment not aborted");
   AST_FETCH_ADDR: assert property (@(posedge clk_sys) disable iff (srst) // R6
      mem_req_valid |-> (mem_req_addr[3:0] == seg_base_reg[3:0]) && (mem_req_addr - seg_base_reg == {44'h0, idx_reg, 4'h0}))
      else $error("descriptor fetched from wrong slot");
   AST_BAD_TYPE: assert property (@(posedge clk_sys) disable iff (srst) // R8
      (state_reg == ST_DECODE) && (desc_type(desc_reg) > SGW_TYPE_LASTSEG) |=> ##1 (cpl.done && cpl.err == SGW_ERR_TYPE))
      else $error("reserved type not flagged");
   AST_NIBBLE: assert property (@(posedge clk_sys) disable iff (srst) // R13
      (state_reg == ST_DECODE) && (d_type <= SGW_TYPE_DISCARD) && (d_nib != 4'h0) |=> !xfer_valid && (err_reg == SGW_ERR_TYPE))
      else $error("nonzero low nibble not flagged");
   AST_NULL: assert property (@(posedge clk_sys) disable iff (srst) // R9
      (state_reg == ST_DECODE) && (desc_reg == 128'h0) |=> !xfer_valid && (err_reg == SGW_ERR_NONE))
      else $error("null descriptor mishandled");
   AST_OVERFLOW: assert property (@(posedge clk_sys) disable iff (srst) // R12
      (state_reg == ST_DECODE) && !d_chain && (d_type == SGW_TYPE_DATA) && (d_nib == 4'h0) && past_top(d_addr, d_len)
      |=> ##1 (cpl.err == SGW_ERR_LEN))
      else $error("address overflow not flagged");
   AST_FIELDS: assert property (@(posedge clk_sys) disable iff (srst) // R10
      xfer_valid && !$past(xfer_valid) |-> (xfer.addr == $past(d_addr)) && (xfer.len == $past(d_len)))
      else $error("transfer fields not taken from descriptor");
   AST_SRC_DISCARD: assert property (@(posedge clk_sys) disable iff (srst) // R16
      xfer_valid |-> (!xfer.discard || ctrl_reg[SGW_CTRL_DEST]) && (xfer.len != 32'h0))
      else $error("empty or source-side transfer issued");
   AST_STOP: assert property (@(posedge clk_sys) disable iff (srst) // R18
      cpl.done && (cpl.err != SGW_ERR_NONE) |-> !xfer_valid ##1 (irq_stat_reg[SGW_IRQ_ERR] && !mem_req_valid))
      else $error("failure not reported or walk continued");
endmodule

/* File: testbench/sgw_host_mem.sv */
`timescale 1ns/1ns
// host memory model: one outstanding fetch, prompt or slow
module sgw_host_mem (
   // clock and pace
   input  wire logic          clk_sys,
   input  wire logic          slow,
   // fetch port
   input  wire logic          mem_req_valid,
   input  wire logic [63:0]   mem_req_addr,
   output logic               mem_req_ready,
   output logic               mem_rsp_valid,
   output logic      [127:0]  mem_rsp_data
);
   logic [127:0] mem [0:63];  // segments filled by the bench on quadword bounds
   logic         pend_reg = 1'b0;   // fetch accepted, answer owed
   logic [5:0]   idx_reg;           // slot being answered
   logic [1:0]   wait_reg;          // extra latency when slow
   logic         tick_reg = 1'b0;   // stall phase of ready
   initial mem_rsp_valid = 1'b0;
   initial mem_rsp_data = '0;
   assign mem_req_ready = !pend_reg && (!slow || tick_reg);
   // accept, delay, answer; data scrambles in every cycle that gives no answer
   always @(posedge clk_sys) begin
      tick_reg <= !tick_reg;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= ~mem_rsp_data;
      if (pend_reg && wait_reg == 2'h0) begin
         mem_rsp_valid <= 1'b1;
         mem_rsp_data <= mem[idx_reg];
         pend_reg <= 1'b0;
      end else if (pend_reg) begin
         wait_reg <= wait_reg - 2'h1;
      end
      if (mem_req_valid && mem_req_ready) begin
         pend_reg <= 1'b1;
         idx_reg <= mem_req_addr[9:4];
         wait_reg <= slow ? 2'h3 : 2'h0;
      end
   end
endmodule

/* File: testbench/tb_sgw_walker.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin miscompares++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module tb_sgw_walker;
   import sgw_pkg::*;
   logic         clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, xfer_ready = 1'b0, slow = 1'b0;
   logic [7:0]   reg_addr = 8'h00;
   logic [31:0]  reg_wdata = 32'h0, reg_rdata, rd_v;
   logic         mem_req_valid, mem_req_ready, mem_rsp_valid, xfer_valid, irq;
   logic [63:0]  mem_req_addr;
   logic [127:0] mem_rsp_data;
   sgw_xfer_t    xfer, lx;
   sgw_cpl_t     cpl;
   int           miscompares = 0, n_tests = 0, nx;
   initial forever #50 clk_sys = ~clk_sys;
   sgw_walker dut_u (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_req_valid,
      .mem_req_addr, .mem_req_ready, .mem_rsp_valid, .mem_rsp_data, .xfer_valid, .xfer, .xfer_ready, .cpl, .irq);
   sgw_host_mem u_mem (.clk_sys, .slow, .mem_req_valid, .mem_req_addr, .mem_req_ready, .mem_rsp_valid,
      .mem_rsp_data);
   // descriptor image; reserved bytes 14:12 carry junk on purpose
   function automatic logic [127:0] dsc(logic [3:0] ty, logic [3:0] nb, logic [63:0] a, logic [31:0] l);
      return {ty, nb, 24'ha5a5a5, l, a};
   endfunction
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_sys); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk_sys); reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk_sys); reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk_sys); reg_rd <= 1'b0;
      @(negedge clk_sys); rd_v = reg_rdata;
   endtask
   // program one walk, take transfers until completion, judge status and count
   task automatic walk(logic [31:0] base, logic [15:0] cnt, logic [2:0] ctl, logic [2:0] ee, int en);
      nx = 0;
      wr(SGW_OFS_SEG_LO, base); wr(SGW_OFS_SEG_HI, 32'h0); wr(SGW_OFS_SEG_CNT, {16'h0, cnt});
      wr(SGW_OFS_CTRL, {29'h0, ctl});
      for (int i = 0; i < 400 && cpl.done !== 1'b1; i++) begin
         @(posedge clk_sys);
         if (xfer_valid === 1'b1 && xfer_ready === 1'b1) begin nx++; lx = xfer; end
         xfer_ready <= slow ? ~xfer_ready : 1'b1;
      end
      `CHK("cpl_done", 1'b1, cpl.done)
      `CHK("cpl_err", ee, cpl.err)
      `CHK("xfer_count", en, nx)
   endtask
   task automatic t_plain;
      u_mem.mem[0] = '0;
      u_mem.mem[1] = dsc(SGW_TYPE_DATA, 4'h0, 64'h1234_5678_9abc_def3, 32'h5);
      wr(SGW_OFS_IRQ_MASK, 32'h3);
      walk(32'h0, 16'h2, 3'b101, SGW_ERR_NONE, 1);
      `CHK("addr", 64'h1234_5678_9abc_def3, lx.addr)
      `CHK("len", 32'h5, lx.len)
      repeat (3) @(posedge clk_sys);
      `CHK("irq_on", 1'b1, irq)
      wr(SGW_OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_sys);
      `CHK("irq_masked", 1'b0, irq)
      rd(SGW_OFS_IRQ_STAT); `CHK("irq_stat", 32'h1, rd_v)
      wr(SGW_OFS_IRQ_STAT, 32'h1);
      rd(SGW_OFS_IRQ_STAT); `CHK("irq_clr", 32'h0, rd_v)
      rd(8'h1c); `CHK("unmapped", 32'h0, rd_v)
      $display("test plain done");
   endtask
   task automatic t_chain;
      slow = 1'b1;
      u_mem.mem[4] = dsc(SGW_TYPE_DATA, 4'h0, 64'h10, 32'h1);
      u_mem.mem[5] = dsc(SGW_TYPE_SEG, 4'h0, 64'h100, 32'h20);
      u_mem.mem[16] = dsc(SGW_TYPE_DATA, 4'h0, 64'h20, 32'h2);
      u_mem.mem[17] = dsc(SGW_TYPE_LASTSEG, 4'h0, 64'h200, 32'h10);
      u_mem.mem[32] = dsc(SGW_TYPE_DATA, 4'h0, 64'h30, 32'h3);
      walk(32'h40, 16'h2, 3'b001, SGW_ERR_NONE, 3);
      `CHK("chain_addr", 64'h30, lx.addr)
      slow <= 1'b0;
      rd(SGW_OFS_STATUS); `CHK("status_chain", 32'h0003_0000, rd_v)
      $display("test chain done");
   endtask
   task automatic t_errs;
      u_mem.mem[0] = dsc(SGW_TYPE_SEG, 4'h0, 64'h100, 32'h10);
      u_mem.mem[1] = dsc(SGW_TYPE_DATA, 4'h0, 64'h0, 32'h1);
      walk(32'h0, 16'h2, 3'b001, SGW_ERR_CHAIN, 0);
      rd(SGW_OFS_STATUS); `CHK("status_err", 32'h0000_0030, rd_v)
      walk(32'h0, 16'h0, 3'b101, SGW_ERR_SEGLEN, 0);
      u_mem.mem[0] = dsc(SGW_TYPE_SEG, 4'h0, 64'h100, 32'h18);
      walk(32'h0, 16'h1, 3'b001, SGW_ERR_SEGLEN, 0);
      u_mem.mem[0] = dsc(SGW_TYPE_DATA, 4'h0, 64'h8, 32'h4);
      u_mem.mem[1] = dsc(SGW_TYPE_LASTSEG, 4'h0, 64'h100, 32'h10);
      walk(32'h0, 16'h2, 3'b101, SGW_ERR_LASTSEG, 1);
      for (int t = 4; t < 16; t++) begin
         u_mem.mem[0] = dsc(t[3:0], 4'h0, 64'h0, 32'h1);
         walk(32'h0, 16'h1, 3'b101, SGW_ERR_TYPE, 0);
      end
      u_mem.mem[0] = dsc(SGW_TYPE_DATA, 4'h1, 64'h0, 32'h1);
      walk(32'h0, 16'h1, 3'b101, SGW_ERR_TYPE, 0);
      u_mem.mem[0] = dsc(SGW_TYPE_DATA, 4'h0, 64'hffff_ffff_ffff_fff0, 32'h10);
      walk(32'h0, 16'h1, 3'b101, SGW_ERR_NONE, 1);
      u_mem.mem[0] = dsc(SGW_TYPE_DATA, 4'h0, 64'hffff_ffff_ffff_fff0, 32'h11);
      walk(32'h0, 16'h1, 3'b101, SGW_ERR_LEN, 0);
      $display("test errors done");
   endtask
   task automatic t_disc;
      u_mem.mem[0] = dsc(SGW_TYPE_DISCARD, 4'h0, 64'h0, 32'h7);
      walk(32'h0, 16'h1, 3'b111, SGW_ERR_NONE, 1);
      `CHK("disc_flag", 1'b1, lx.discard)
      `CHK("disc_len", 32'h7, lx.len)
      walk(32'h0, 16'h1, 3'b101, SGW_ERR_NONE, 0);
      $display("test discard done");
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      rd(SGW_OFS_IRQ_MASK); `CHK("mask_rst", SGW_RST_WORD, rd_v)
      t_plain;
      t_chain;
      t_errs;
      t_disc;
      final_report;
   end
   // watchdog well beyond the expected several hundred cycles
   initial begin
      repeat (30000) @(posedge clk_sys);
      miscompares++;
      final_report;
   end
endmodule
